// >>> core/rcoc_defs.vh
// Constants for the reference clock output configuration block
`ifndef RCOC_DEFS_VH
`define RCOC_DEFS_VH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define RCOC_ADR_CFG 4'h0
`define RCOC_ADR_SRCA 4'h4
`define RCOC_ADR_SRCB 4'h8
`define RCOC_ADR_STAT 4'hC
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define RCOC_B_JAB 6
`define RCOC_B_LVL 5
`define RCOC_B_SYB 4
`define RCOC_B_FREE 3
`define RCOC_B_EN 6
`define RCOC_CFG_RST 8'h30
`define RCOC_SRCA_RST 8'h41
`define RCOC_SRCB_RST 8'h41
`define RCOC_LAST_CH 5'h15
`define RCOC_NCH 22
// ------------------------------------------------------------
// Timing: master clock 100 MHz, half periods in cycles
// ------------------------------------------------------------
`define RCOC_CLK_HZ 100000000
`define RCOC_HALF_2M048 24
`define RCOC_HALF_64K 781
`define RCOC_HALF_8K 6250
`define RCOC_LOSS_CYC 16'h0200
`endif

// >>> core/rcoc_rate_gen.v
// Rate generator: a free clock divided from the master clock
`timescale 1ns/1ns
module rcoc_rate_gen (
   input wire I_CLK,
   input wire I_NRST,
   input wire i_sync,
   input wire [12:0] i_half,
   output reg o_clk
);
   reg [12:0] cnt_q;
   // ------------------------------------------------------------
   // Divider, restarted by a sync pulse to lock phase
   // ------------------------------------------------------------
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cnt_q <= 13'h0000;
         o_clk <= 1'b0;
      end else if (i_sync) begin
         cnt_q <= 13'h0000;
         o_clk <= 1'b1;
      end else if (cnt_q >= i_half - 13'h0001) begin
         cnt_q <= 13'h0000;
         o_clk <= ~o_clk;
      end else begin
         cnt_q <= cnt_q + 13'h0001;
      end
   end
endmodule // rcoc_rate_gen

// >>> core/rcoc_top.v
// Reference clock output A/B selection, synthesis and loss handling
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "rcoc_defs.vh"
module rcoc_top (
   input wire I_CLK,
   input wire I_NRST,
   input wire [3:0] I_WB_ADR,
   input wire [31:0] I_WB_DAT,
   input wire I_WB_WE,
   input wire [3:0] I_WB_SEL,
   input wire I_WB_CYC,
   input wire I_WB_STB,
   output reg [31:0] O_WB_DAT,
   output reg O_WB_ACK,
   input wire [21:0] I_REC_CLK,
   input wire [21:0] I_REC_CLK_JA,
   input wire I_EXT_CLK_A,
   input wire I_EXT_CLK_B,
   output reg O_REF_A,
   output reg O_REF_A_OE,
   output reg O_REF_B,
   output reg O_REF_B_OE
);
   reg [7:0] cfg_q;
   reg [7:0] srca_q;
   reg [7:0] srcb_q;
   reg [21:0] rec_s1_q, rec_s2_q, ja_s1_q, ja_s2_q;
   reg [1:0] ext_s1_q, ext_s2_q;
   reg [21:0] rec_lost_q, ja_lost_q;
   wire [21:0] rec_sel_v;
   reg sel_a_q, sel_b_q, sel_a_d, sel_b_d;
   reg prev_a_q, prev_b_q;
   reg [15:0] loss_a_q, loss_b_q;
   reg lost_a_q, lost_b_q;
   reg [15:0] ext_cnt_a_q, ext_cnt_b_q;
   reg [2:0] loss_cnt_q;
   wire [7:0] w_mask;
   wire rd, wr;
   wire [2:0] rate;
   wire a_ext, b_ext;
   wire a_edge;
   reg [12:0] half_a;
   wire clk_2m, clk_a_syn, clk_a_free;
   reg out_a_d, out_b_d;

   // ------------------------------------------------------------
   // Wishbone slave, one registered ack per request, in the cycle after it
   // ------------------------------------------------------------
   assign rd = I_WB_CYC & I_WB_STB & ~I_WB_WE & ~O_WB_ACK;
   assign wr = I_WB_CYC & I_WB_STB & I_WB_WE & ~O_WB_ACK & I_WB_SEL[0];
   assign w_mask = I_WB_DAT[7:0];
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cfg_q <= `RCOC_CFG_RST;
         srca_q <= `RCOC_SRCA_RST;
         srcb_q <= `RCOC_SRCB_RST;
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= I_WB_CYC & I_WB_STB & ~O_WB_ACK;
         if (wr) begin
            if (I_WB_ADR == `RCOC_ADR_CFG) begin
               cfg_q <= {1'b0, w_mask[6:0]};
            end else if (I_WB_ADR == `RCOC_ADR_SRCA) begin
               srca_q <= {1'b0, w_mask[6:0]};
            end else if (I_WB_ADR == `RCOC_ADR_SRCB) begin
               srcb_q <= {1'b0, w_mask[6:0]};
            end
         end
         if (rd) begin
            if (I_WB_ADR == `RCOC_ADR_CFG) begin
               O_WB_DAT <= {24'h000000, cfg_q};
            end else if (I_WB_ADR == `RCOC_ADR_SRCA) begin
               O_WB_DAT <= {24'h000000, srca_q};
            end else if (I_WB_ADR == `RCOC_ADR_SRCB) begin
               O_WB_DAT <= {24'h000000, srcb_q};
            end else if (I_WB_ADR == `RCOC_ADR_STAT) begin
               O_WB_DAT <= {30'h00000000, lost_b_q, lost_a_q};
            end else begin
               O_WB_DAT <= 32'h00000000;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rec_s1_q <= 22'h000000;
         rec_s2_q <= 22'h000000;
         ja_s1_q <= 22'h000000;
         ja_s2_q <= 22'h000000;
         ext_s1_q <= 2'h0;
         ext_s2_q <= 2'h0;
      end else begin
         rec_s1_q <= I_REC_CLK;
         rec_s2_q <= rec_s1_q;
         ja_s1_q <= I_REC_CLK_JA;
         ja_s2_q <= ja_s1_q;
         ext_s1_q <= {I_EXT_CLK_B, I_EXT_CLK_A};
         ext_s2_q <= ext_s1_q;
      end
   end

   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   // Jitter attenuated or raw recovered clock per channel
   genvar g;
   generate
      for (g = 0; g < `RCOC_NCH; g = g + 1) begin : g_ch
         assign rec_sel_v[g] = cfg_q[`RCOC_B_JAB] ? rec_s2_q[g] :
            ja_s2_q[g];
      end
   endgenerate
   assign a_ext = srca_q[4:0] > `RCOC_LAST_CH;
   assign b_ext = srcb_q[4:0] > `RCOC_LAST_CH;
   always @* begin
      sel_a_d = a_ext ? ext_s2_q[0] : rec_sel_v[srca_q[4:0]];
      sel_b_d = b_ext ? ext_s2_q[1] : rec_sel_v[srcb_q[4:0]];
   end
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         sel_a_q <= 1'b0;
         sel_b_q <= 1'b0;
         prev_a_q <= 1'b0;
         prev_b_q <= 1'b0;
      end else begin
         sel_a_q <= sel_a_d;
         sel_b_q <= sel_b_d;
         prev_a_q <= sel_a_q;
         prev_b_q <= sel_b_q;
      end
   end
   assign a_edge = sel_a_q & ~prev_a_q;

   // ------------------------------------------------------------
   // Loss of clock: no edge for a fixed count of cycles
   // ------------------------------------------------------------
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         loss_a_q <= 16'h0000;
         loss_b_q <= 16'h0000;
         lost_a_q <= 1'b1;
         lost_b_q <= 1'b1;
      end else begin
         if (sel_a_q != prev_a_q) begin
            loss_a_q <= 16'h0000;
            lost_a_q <= 1'b0;
         end else if (loss_a_q >= `RCOC_LOSS_CYC) begin
            lost_a_q <= 1'b1;
         end else begin
            loss_a_q <= loss_a_q + 16'h0001;
         end
         if (sel_b_q != prev_b_q) begin
            loss_b_q <= 16'h0000;
            lost_b_q <= 1'b0;
         end else if (loss_b_q >= `RCOC_LOSS_CYC) begin
            lost_b_q <= 1'b1;
         end else begin
            loss_b_q <= loss_b_q + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Rate decode and generators
   // ------------------------------------------------------------
   assign rate = cfg_q[2:0];
   always @* begin
      case (rate)
         3'h0: half_a = 13'd`RCOC_HALF_2M048;
         3'h1: half_a = 13'd`RCOC_HALF_8K;
         3'h2: half_a = 13'd`RCOC_HALF_64K;
         default: half_a = 13'd`RCOC_HALF_2M048;
      endcase
   end
   // Locked: restarted on each source rising edge when rate is not 0
   rcoc_rate_gen u_syn (
      .I_CLK(I_CLK),
      .I_NRST(I_NRST),
      .i_sync(a_edge & (rate != 3'h0)),
      .i_half(half_a),
      .o_clk(clk_a_syn)
   );
   rcoc_rate_gen u_free (
      .I_CLK(I_CLK),
      .I_NRST(I_NRST),
      .i_sync(1'b0),
      .i_half(half_a),
      .o_clk(clk_a_free)
   );
   rcoc_rate_gen u_b (
      .I_CLK(I_CLK),
      .I_NRST(I_NRST),
      .i_sync(1'b0),
      .i_half(13'd`RCOC_HALF_2M048),
      .o_clk(clk_2m)
   );

   // ------------------------------------------------------------
   // Output A and B selection
   // ------------------------------------------------------------
   always @* begin
      if (cfg_q[`RCOC_B_SYB]) begin
         // Bypass: source passes straight through unless a recovered source is lost
         out_a_d = sel_a_q;
         if (lost_a_q && !a_ext) begin
            out_a_d = cfg_q[`RCOC_B_LVL] ? 1'b1 : clk_a_free;
         end
      end else if (cfg_q[`RCOC_B_FREE]) begin
         out_a_d = clk_a_free;
      end else if (lost_a_q) begin
         out_a_d = 1'b1;
      end else begin
         out_a_d = (rate == 3'h0) ? sel_a_q : clk_a_syn;
      end
      if (lost_b_q) begin
         out_b_d = cfg_q[`RCOC_B_LVL] ? 1'b1 : clk_2m;
      end else begin
         out_b_d = sel_b_q;
      end
   end
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_REF_A <= 1'b1;
         O_REF_B <= 1'b1;
         O_REF_A_OE <= 1'b0;
         O_REF_B_OE <= 1'b0;
      end else begin
         O_REF_A <= out_a_d;
         O_REF_B <= out_b_d;
         O_REF_A_OE <= srca_q[`RCOC_B_EN];
         O_REF_B_OE <= srcb_q[`RCOC_B_EN];
      end
   end
endmodule // rcoc_top

// >>> tb/rcoc_asserts.sv
// Bus and output enable checker for the reference clock block
`timescale 1ns/1ns
module rcoc_asserts (
   input wire I_CLK,
   input wire I_NRST,
   input wire [3:0] I_WB_ADR,
   input wire [31:0] I_WB_DAT,
   input wire I_WB_WE,
   input wire [3:0] I_WB_SEL,
   input wire I_WB_CYC,
   input wire I_WB_STB,
   input wire [31:0] O_WB_DAT,
   input wire O_WB_ACK,
   input wire O_REF_A_OE,
   input wire O_REF_B_OE
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   wire req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   wire wr = req && I_WB_WE && I_WB_SEL[0];
   wire rd_ack = O_WB_ACK && !I_WB_WE;
   property p_ack; req |=> O_WB_ACK; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_cause; O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB); endproperty
   a_cause: assert property (p_cause) else $error("ack unasked");
   property p_upper; rd_ack |-> O_WB_DAT[31:7] == 25'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_unmap; rd_ack && I_WB_ADR[1:0] != 2'h0 |-> O_WB_DAT == 0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   property p_hold; !$stable(O_WB_DAT) |-> rd_ack; endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_oe_a; wr && I_WB_ADR == 4'h4 && !I_WB_DAT[6]
      |-> ##[1:3] !O_REF_A_OE; endproperty
   a_oe_a: assert property (p_oe_a) else $error("A not off");
   property p_oe_b; wr && I_WB_ADR == 4'h8 && I_WB_DAT[6]
      |-> ##[1:3] O_REF_B_OE; endproperty
   a_oe_b: assert property (p_oe_b) else $error("B not on");
endmodule // rcoc_asserts
bind rcoc_top rcoc_asserts chk_u (.I_CLK(I_CLK), .I_NRST(I_NRST),
   .I_WB_ADR(I_WB_ADR), .I_WB_DAT(I_WB_DAT), .I_WB_WE(I_WB_WE),
   .I_WB_SEL(I_WB_SEL), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
   .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .O_REF_A_OE(O_REF_A_OE), .O_REF_B_OE(O_REF_B_OE));

// >>> tb/rcoc_top_test.sv
// Self-checking bench for the reference clock block
`timescale 1ns/1ns
module rcoc_top_test;
   reg I_CLK = 0, I_NRST = 0, we = 0, cyc = 0, ext_b = 0, run_b = 0;
   reg [3:0] adr = 0, sel = 4'hF;
   reg [21:0] rec = 0;
   reg run_r = 0;
   reg [31:0] wd = 0, lfsr = 32'h1D18, expq[$];
   wire [31:0] rd;
   wire ack, ref_a, oe_a, ref_b, oe_b;
   integer num_errors = 0, num_checks = 0, n, c;
   always #5 I_CLK = ~I_CLK;
   always @(posedge I_CLK) if (run_b) ext_b <= ~ext_b;
   always @(posedge I_CLK) if (run_r) rec <= ~rec;
   rcoc_top dut_u (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_WB_ADR(adr),
      .I_WB_DAT(wd), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_CYC(cyc),
      .I_WB_STB(cyc), .O_WB_DAT(rd), .O_WB_ACK(ack),
      .I_REC_CLK(rec), .I_REC_CLK_JA(22'h0), .I_EXT_CLK_A(1'b0),
      .I_EXT_CLK_B(ext_b), .O_REF_A(ref_a), .O_REF_A_OE(oe_a),
      .O_REF_B(ref_b), .O_REF_B_OE(oe_b));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function [31:0] nxt(input [31:0] v);
      nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task wb(input [3:0] a, input w, input [31:0] d, input [31:0] e);
      begin
         if (!w)
            expq.push_back(e);
         adr <= a;
         we <= w;
         wd <= d;
         cyc <= 1'b1;
         @(posedge I_CLK);
         while (ack !== 1'b1)
            @(posedge I_CLK);
         cyc <= 1'b0;
         @(posedge I_CLK);
      end
   endtask
   task tog(input s, input integer cy, output integer t);
      reg p;
      begin
         t = 0;
         p = s ? ref_b : ref_a;
         repeat (cy) begin
            @(posedge I_CLK);
            if ((s ? ref_b : ref_a) !== p)
               t = t + 1;
            p = s ? ref_b : ref_a;
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d errors %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   always @(posedge I_CLK)
      if (ack === 1'b1 && we === 1'b0) chk(rd, expq.pop_front());
   initial begin
      #600000;
      num_errors = num_errors + 1;
      end_sim;
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge I_CLK);
      I_NRST <= 1'b1;
      @(posedge I_CLK);
      wb(4'h0, 0, 0, 32'h30);
      wb(4'h4, 0, 0, 32'h41);
      wb(4'h8, 0, 0, 32'h41);
      wb(4'h2, 0, 0, 0);
      wb(4'hC, 0, 0, 32'h3);
      repeat (4) begin
         lfsr = nxt(lfsr);
         wb(4'h0, 1, lfsr, 0);
         wb(4'h0, 0, 0, {25'h0, lfsr[6:0]});
      end
      $display("registers done");
      run_b <= 1'b1;
      wb(4'h8, 1, 32'h56, 0);
      repeat (100) @(posedge I_CLK);
      wb(4'hC, 0, 0, 32'h1);
      wb(4'h8, 1, 32'h55, 0);
      repeat (600) @(posedge I_CLK);
      wb(4'hC, 0, 0, 32'h3);
      wb(4'h0, 1, 32'h10, 0);
      tog(1, 480, n);
      chk(n >= 19 && n <= 21, 1);
      wb(4'h0, 1, 32'h30, 0);
      tog(1, 480, n);
      chk({n, ref_b}, 1);
      run_b <= 1'b0;
      $display("output B done");
      wb(4'h4, 1, 32'h56, 0);
      wb(4'h0, 1, 32'h00, 0);
      repeat (600) @(posedge I_CLK);
      chk(ref_a, 1);
      for (c = 1; c <= 2; c = c + 1) begin
         wb(4'h0, 1, 32'h08 | c, 0);
         tog(0, c == 1 ? 25000 : 3124, n);
         chk(n >= 3 && n <= 5, 1);
      end
      run_r <= 1'b1;
      wb(4'h4, 1, 32'h40, 0);
      wb(4'h0, 1, 32'h50, 0);
      repeat (10) @(posedge I_CLK);
      tog(0, 40, n);
      chk(n >= 38 && n <= 40, 1);
      wb(4'h0, 1, 32'h40, 0);
      repeat (10) @(posedge I_CLK);
      tog(0, 40, n);
      chk(n >= 38 && n <= 40, 1);
      wb(4'h0, 1, 32'h30, 0);
      repeat (600) @(posedge I_CLK);
      chk(ref_a, 1);
      wb(4'h0, 1, 32'h10, 0);
      tog(0, 480, n);
      chk(n >= 19 && n <= 21, 1);
      run_r <= 1'b0;
      chk(oe_b, 1);
      wb(4'h4, 1, 32'h16, 0);
      repeat (3) @(posedge I_CLK);
      chk(oe_a, 0);
      $display("output A done");
      end_sim;
   end
endmodule // rcoc_top_test
